// ---- port_clock_pkg.sv ----
package port_clock_pkg;
  localparam logic [7:0] PORT_CLOCK_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] CLOCK_STATUS_ADDR = 8'h04;
  localparam logic [15:0] PORT_CLOCK_CONTROL_RESET = 16'h0000;
  localparam int RUN_DEBUG_BIT = 8;
  localparam int DIV_LSB = 4;
  localparam int KEY_LSB = 2;
  localparam int SRC_LSB = 0;
  localparam int DIV_STAGES = 15;

  typedef enum logic [1:0] {
    src_internal_oscillator,
    src_first_oscillator,
    src_third_oscillator,
    src_external_clock_input
  } clock_source_select_type;

  typedef enum logic [1:0] {
    key_off,
    key_two_inputs,
    key_three_inputs,
    key_four_inputs
  } key_reset_config_type;

  typedef struct packed {
    logic run_while_debugging;
    logic [3:0] clock_divider_select;
    key_reset_config_type key_reset_config;
    clock_source_select_type clock_source_select;
  } port_clock_control_type;

  typedef struct packed {
    logic internal_oscillator;
    logic first_oscillator;
    logic third_oscillator;
    logic external_clock_input;
  } source_ticks_type;

  localparam logic [3:0] SOURCE_PRESENT = 4'hf;
endpackage

// ---- port_clock_keyreset_config.sv ----
`timescale 1ns/1ns
// Overview of operation
// - Run-while-debugging bit gates the operating clock while debug halted.
// - Four-bit divider field selects the ratio applied to the chosen source.
// - Key reset fires when selected low inputs of group zero all read low.
// - Two-bit source field picks internal, first, third or external clock.
// - First oscillator source divides by two to the power of divider code.
// - External clock input passes undivided whatever the divider says.
// - Filter sample tick follows the divided operating clock period.
// - Writes naming a source absent from this part leave the source field unchanged.
module port_clock_keyreset_config
  import port_clock_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic write_unlocked_i,
  input wire logic debug_halt_i,
  input wire source_ticks_type source_ticks_i,
  input wire logic [3:0] port_group_zero_i,
  output logic filter_tick_o,
  output logic key_reset_o
);
  port_clock_control_type ctrl_r;
  logic [DIV_STAGES-1:0] div_cnt_r;
  logic src_tick;
  logic div_hit;
  logic [3:0] key_mask;

  function automatic logic source_ok(input logic [1:0] code);
    source_ok = SOURCE_PRESENT[code];
  endfunction

  // Register write; an illegal source keeps the previous source setting.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <=
        port_clock_control_type'(PORT_CLOCK_CONTROL_RESET[RUN_DEBUG_BIT:0]);
    end else if (wr_i && addr_i == PORT_CLOCK_CONTROL_ADDR
                 && write_unlocked_i) begin
      ctrl_r.run_while_debugging <= wdata_i[RUN_DEBUG_BIT];
      ctrl_r.clock_divider_select <= wdata_i[DIV_LSB +: 4];
      ctrl_r.key_reset_config <=
        key_reset_config_type'(wdata_i[KEY_LSB +: 2]);
      if (source_ok(wdata_i[SRC_LSB +: 2])) begin
        ctrl_r.clock_source_select <=
          clock_source_select_type'(wdata_i[SRC_LSB +: 2]);
      end
    end
  end

  // A refused write must leave every field alone, not only the source.
  a_locked_no_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && !write_unlocked_i) |=> $stable(ctrl_r))
    else $error("write while locked");

  a_write_lands: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && write_unlocked_i && addr_i == PORT_CLOCK_CONTROL_ADDR)
    |=> ctrl_r.clock_divider_select == $past(wdata_i[DIV_LSB +: 4]))
    else $error("divider write lost");

  a_source_legal: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    source_ok(ctrl_r.clock_source_select))
    else $error("absent source selected");

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        PORT_CLOCK_CONTROL_ADDR: rdata_o <= {7'h00, ctrl_r};
        CLOCK_STATUS_ADDR: rdata_o <= {14'h0000, key_reset_o, filter_tick_o};
        default: rdata_o <= 16'h0000;
      endcase
    end
  end

  a_reserved_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == PORT_CLOCK_CONTROL_ADDR)
    |=> rdata_o[15:9] == 7'h00)
    else $error("reserved bits nonzero");

  // Status is a snapshot taken at the read edge; polling can miss a tick.
  a_status_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == CLOCK_STATUS_ADDR)
    |=> rdata_o[15:2] == 14'h0000)
    else $error("status reserved bits nonzero");

  a_unmapped_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i != PORT_CLOCK_CONTROL_ADDR
     && addr_i != CLOCK_STATUS_ADDR) |=> rdata_o == 16'h0000)
    else $error("unmapped read nonzero");

  always_comb begin
    case (ctrl_r.clock_source_select)
      src_internal_oscillator: src_tick = source_ticks_i.internal_oscillator;
      src_first_oscillator: src_tick = source_ticks_i.first_oscillator;
      src_third_oscillator: src_tick = source_ticks_i.third_oscillator;
      src_external_clock_input: src_tick = source_ticks_i.external_clock_input;
      default: src_tick = 1'b0;
    endcase
  end

  a_source_routing: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r.clock_source_select == src_first_oscillator
     && !source_ticks_i.first_oscillator) |=> !filter_tick_o)
    else $error("tick from unselected source");

  // Division counts source ticks; code n completes after 2**n ticks.
  always_comb begin
    div_hit = 1'b1;
    if (ctrl_r.clock_source_select != src_external_clock_input) begin
      for (int i = 0; i < DIV_STAGES; i++) begin
        if (i < int'(ctrl_r.clock_divider_select) && !div_cnt_r[i]) begin
          div_hit = 1'b0;
        end
      end
    end
  end

  a_div_one_pass: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r.clock_divider_select == 4'h0 && src_tick && !debug_halt_i)
    |=> filter_tick_o)
    else $error("ratio one lost tick");

  a_external_undivided: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r.clock_source_select == src_external_clock_input
     && source_ticks_i.external_clock_input && !debug_halt_i)
    |=> filter_tick_o)
    else $error("external not undivided");

  // The clock is stopped while halted with run_while_debugging clear, so the divider also freezes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_r <= '0;
    end else if (src_tick && !(debug_halt_i
                 && !ctrl_r.run_while_debugging)) begin
      div_cnt_r <= div_hit ? '0 : div_cnt_r + 1'b1;
    end
  end

  a_div_hold_halt: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (debug_halt_i && !ctrl_r.run_while_debugging) |=> $stable(div_cnt_r))
    else $error("divider moved while halted");

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filter_tick_o <= 1'b0;
    end else begin
      filter_tick_o <= src_tick && div_hit
        && !(debug_halt_i && !ctrl_r.run_while_debugging);
    end
  end

  a_debug_gate_tick: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (debug_halt_i && !ctrl_r.run_while_debugging) |=> !filter_tick_o)
    else $error("tick while debug halted");

  a_debug_run_tick: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (debug_halt_i && ctrl_r.run_while_debugging && src_tick && div_hit)
    |=> filter_tick_o)
    else $error("tick lost while debug running");

  a_tick_needs_src: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !src_tick |=> !filter_tick_o)
    else $error("tick without source");

  always_comb begin
    case (ctrl_r.key_reset_config)
      key_two_inputs: key_mask = 4'h3;
      key_three_inputs: key_mask = 4'h7;
      key_four_inputs: key_mask = 4'hf;
      default: key_mask = 4'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_reset_o <= 1'b0;
    end else begin
      key_reset_o <= (key_mask != 4'h0)
        && ((port_group_zero_i & key_mask) == 4'h0);
    end
  end

  a_key_reset_fire: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r.key_reset_config == key_four_inputs && port_group_zero_i == 4'h0)
    |=> key_reset_o)
    else $error("key reset missed");

  a_key_three_fire: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r.key_reset_config == key_three_inputs
     && port_group_zero_i[2:0] == 3'h0) |=> key_reset_o)
    else $error("three input key reset missed");

  a_key_two_fire: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r.key_reset_config == key_two_inputs
     && port_group_zero_i[1:0] == 2'h0) |=> key_reset_o)
    else $error("two input key reset missed");

  // Inputs 1..0 take part in every enabled setting, so either high blocks.
  a_key_low_needed: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (port_group_zero_i[0] || port_group_zero_i[1]) |=> !key_reset_o)
    else $error("key reset with input high");

  a_key_reset_off: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r.key_reset_config == key_off) |=> !key_reset_o)
    else $error("key reset while disabled");
endmodule

// ---- port_clock_keyreset_config_tb.sv ----
`timescale 1ns/1ns
module port_clock_keyreset_config_tb;
  import port_clock_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic write_unlocked_i = 1'b1, debug_halt_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o, v, d;
  logic [3:0] port_group_zero_i = 4'hf;
  source_ticks_type source_ticks_i = '0;
  logic filter_tick_o, key_reset_o;
  int miscompares = 0, cmp_count = 0, c;
  always #50 clk_i = ~clk_i;
  port_clock_keyreset_config u_port_clock_keyreset_config (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .write_unlocked_i(write_unlocked_i),
    .debug_halt_i(debug_halt_i), .source_ticks_i(source_ticks_i),
    .port_group_zero_i(port_group_zero_i), .filter_tick_o(filter_tick_o),
    .key_reset_o(key_reset_o));
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= w;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] r);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    r = rdata_o;
  endtask
  // Ticks are counted two cycles past the last pulse to catch the lag.
  task ticks(input logic [3:0] pat, input int m, output int n);
    n = 0;
    for (int i = 0; i < m + 2; i++) begin
      @(posedge clk_i);
      source_ticks_i <= (i < m) ? source_ticks_type'(pat) : '0;
      @(negedge clk_i);
      n += int'(filter_tick_o);
    end
  endtask
  function automatic logic key_exp(input logic [1:0] k, input logic [3:0] p);
    return (k != 2'h0) && ((p & ((4'h2 << k) - 4'h1)) == 4'h0);
  endfunction
  task end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(69));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, d); chk("ctrl_reset", d, 16'h0000);
    v = 16'($urandom());
    wr(8'h00, v);
    rd(8'h00, d); chk("ctrl_rw", d, v & 16'h01ff);
    write_unlocked_i <= 1'b0;
    wr(8'h00, ~v);
    write_unlocked_i <= 1'b1;
    rd(8'h00, d); chk("ctrl_locked", d, v & 16'h01ff);
    rd(8'h0c, d); chk("unmapped", d, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 16'(k << 2));
      for (int i = 0; i < 6; i++) begin
        @(posedge clk_i);
        port_group_zero_i <= 4'($urandom() & $urandom());
        @(posedge clk_i);
        @(negedge clk_i);
        d = 16'(key_exp(2'(k), port_group_zero_i));
        chk("key_reset", 16'(key_reset_o), d);
      end
    end
    v = 16'({key_exp(2'd3, port_group_zero_i), 1'b0});
    rd(8'h04, d); chk("status", d, v);
    for (int n = 0; n < 4; n++) begin
      wr(8'h00, 16'((n << 4) | 1));
      ticks(4'b0100, 16, c); chk("div_first", 16'(c), 16'(16 >> n));
    end
    wr(8'h00, 16'h0020);
    ticks(4'b1000, 16, c); chk("div_internal", 16'(c), 16'd4);
    wr(8'h00, 16'h0001);
    ticks(4'b1011, 8, c); chk("src_other", 16'(c), 16'd0);
    wr(8'h00, 16'h0012);
    ticks(4'b0110, 8, c); chk("src_third", 16'(c), 16'd4);
    wr(8'h00, 16'h00f3);
    ticks(4'b0001, 8, c); chk("ext_undiv", 16'(c), 16'd8);
    @(posedge clk_i) debug_halt_i <= 1'b1;
    ticks(4'b0001, 8, c); chk("dbg_stop", 16'(c), 16'd0);
    wr(8'h00, 16'h01f3);
    ticks(4'b0001, 8, c); chk("dbg_run", 16'(c), 16'd8);
    @(posedge clk_i) rst_n_i <= 1'b0;
    @(posedge clk_i) rst_n_i <= 1'b1;
    rd(8'h00, d); chk("ctrl_rerun", d, 16'h0000);
    end_of_test();
  end
endmodule
